// file: src/nvc_map.svh
// Purpose: offsets, field positions and timing counts of the nv memory controller
// Assumes: clk_sys at 100 MHz
// Notes: included by its bare name
`ifndef NVC_MAP_SVH
`define NVC_MAP_SVH

// software register offsets, byte addresses
`define NVC_OFF_CTRL 8'h00
`define NVC_OFF_ADDR 8'h04
`define NVC_OFF_DATA 8'h08
`define NVC_OFF_STAT 8'h0c
`define NVC_OFF_TSET_LO 8'h10
`define NVC_OFF_TSET_HI 8'h14
`define NVC_OFF_TSNP_LO 8'h18
`define NVC_OFF_TSNP_HI 8'h1c

// status bits
`define NVC_ST_BUSY 0
`define NVC_ST_REFUSED 1
`define NVC_ST_DONE 2

// device side map
`define NVC_DEV_FLAGS 17'h1fff0
`define NVC_DEV_CLK_BASE 17'h1fff8
`define NVC_FLAG_RHOLD 8'h01
`define NVC_FLAG_WHOLD 8'h02
`define NVC_FLAG_NONE 8'h00

// special function address sequence, low 16 address bits
`define NVC_SEQ_0 16'h4e38
`define NVC_SEQ_1 16'hb1c7
`define NVC_SEQ_2 16'h83e0
`define NVC_SEQ_3 16'h7c1f
`define NVC_SEQ_4 16'h703f
`define NVC_SEQ_SAVE 16'h8fc0
`define NVC_SEQ_RESTORE 16'h4c63
`define NVC_SEQ_AS_DIS 16'h8b45
`define NVC_SEQ_AS_EN 16'h4b46

// timing
`define NVC_CLK_NS 10
`define NVC_T_ACC_NS 50
`define NVC_ACC_CYC ((`NVC_T_ACC_NS + `NVC_CLK_NS - 1) / `NVC_CLK_NS)
`define NVC_T_SAVE_US 15
`define NVC_SAVE_CYC ((`NVC_T_SAVE_US * 1000 + `NVC_CLK_NS - 1) / `NVC_CLK_NS)
`define NVC_T_RESTORE_US 20
`define NVC_RESTORE_CYC ((`NVC_T_RESTORE_US * 1000 + `NVC_CLK_NS - 1) / `NVC_CLK_NS)

`endif

// file: src/nvc_pkg.sv
// Purpose: types of the nv memory controller
// Assumes: nothing
// Notes: constants live in nvc_map.svh
package nvc_pkg;

   typedef enum logic [5:0] {
      ST_IDLE  = 6'b000001,
      ST_SETUP = 6'b000010,
      ST_ACT   = 6'b000100,
      ST_STRB  = 6'b001000,
      ST_HOLD  = 6'b010000,
      ST_WAIT  = 6'b100000
   } nvc_state_t;

   typedef enum logic [3:0] {
      OP_NONE    = 4'h0,
      OP_READ    = 4'h1,
      OP_WRITE   = 4'h2,
      OP_SAVE    = 4'h3,
      OP_RESTORE = 4'h4,
      OP_AS_DIS  = 4'h5,
      OP_AS_EN   = 4'h6,
      OP_TRD     = 4'h7,
      OP_TWR     = 4'h8
   } nvc_op_t;

   typedef struct packed {
      logic [16:0] addr;
      logic ce_n;
      logic we_n;
      logic oe_n;
      logic [7:0] dq_out;
      logic dq_oe;
   } nvc_pins_t;

endpackage

// file: src/nvc_ctrl.sv
// Purpose: host side controller driving a byte-wide nv memory with calendar clock
// Assumes: AHB-Lite slave for software, one clock, synchronous pin inputs
// Notes: one operation at a time; every pin cycle starts and ends with strobes high
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ns
`include "nvc_map.svh"

module nvc_ctrl (
   input wire logic clk_sys, // system clock
   input wire logic reset_n, // synchronous reset
   input wire logic hsel, // slave select
   input wire logic [31:0] haddr, // bus address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write transfer
   input wire logic [2:0] hsize, // transfer size
   input wire logic [31:0] hwdata, // write data
   input wire logic hready, // bus ready
   output logic [31:0] hrdata, // read data
   output logic hreadyout, // slave ready
   output logic hresp, // response, always okay
   output nvc_pkg::nvc_pins_t mem_pins, // device address, strobes, data out
   input wire logic [7:0] mem_dq_in, // device data in
   input wire logic pwr_low // supply below switch threshold
);

   nvc_pkg::nvc_state_t state_ff;
   nvc_pkg::nvc_op_t op_ff;
   nvc_pkg::nvc_pins_t pins_ff;
   logic [3:0] idx_ff;
   logic [11:0] cnt_ff;
   logic [16:0] addr_ff;
   logic [7:0] wdata_ff, rdata_ff, a_off_ff;
   logic refused_ff, done_ff, hold_set_ff, a_act_ff, a_wr_ff, hreadyout_ff;
   logic [63:0] tset_ff, tsnap_ff;
   logic [31:0] hrdata_ff;

   logic [16:0] st_addr;
   logic [7:0] st_dat;
   logic [2:0] bidx;
   logic [31:0] rd_mux;
   logic st_wr, wr_ctrl, start, refuse, last_step;
   nvc_pkg::nvc_op_t req_op;

   function automatic logic is_seq(input nvc_pkg::nvc_op_t op);
      is_seq = (op == nvc_pkg::OP_SAVE) || (op == nvc_pkg::OP_RESTORE) ||
               (op == nvc_pkg::OP_AS_DIS) || (op == nvc_pkg::OP_AS_EN);
   endfunction
   function automatic logic is_clk(input nvc_pkg::nvc_op_t op);
      is_clk = (op == nvc_pkg::OP_TRD) || (op == nvc_pkg::OP_TWR);
   endfunction
   function automatic logic [3:0] op_len(input nvc_pkg::nvc_op_t op);
      if (is_seq(op)) begin
         op_len = 4'd6;
      end else if (is_clk(op)) begin
         op_len = 4'd10;
      end else begin
         op_len = 4'd1;
      end
   endfunction
   function automatic logic [15:0] seq_addr(input nvc_pkg::nvc_op_t op, input logic [3:0] i);
      case (i)
         4'd0: seq_addr = `NVC_SEQ_0;
         4'd1: seq_addr = `NVC_SEQ_1;
         4'd2: seq_addr = `NVC_SEQ_2;
         4'd3: seq_addr = `NVC_SEQ_3;
         4'd4: seq_addr = `NVC_SEQ_4;
         default: begin
            case (op)
               nvc_pkg::OP_SAVE: seq_addr = `NVC_SEQ_SAVE;
               nvc_pkg::OP_RESTORE: seq_addr = `NVC_SEQ_RESTORE;
               nvc_pkg::OP_AS_DIS: seq_addr = `NVC_SEQ_AS_DIS;
               default: seq_addr = `NVC_SEQ_AS_EN;
            endcase
         end
      endcase
   endfunction

   // bus slave, zero wait states
   assign req_op = nvc_pkg::nvc_op_t'(hwdata[3:0]);
   assign wr_ctrl = a_act_ff && a_wr_ff && (a_off_ff == `NVC_OFF_CTRL);
   assign refuse = wr_ctrl && (state_ff == nvc_pkg::ST_IDLE) && pwr_low &&
                   ((req_op == nvc_pkg::OP_WRITE) || (req_op == nvc_pkg::OP_SAVE) ||
                    (req_op == nvc_pkg::OP_TWR));
   assign start = wr_ctrl && (state_ff == nvc_pkg::ST_IDLE) && !refuse &&
                  (req_op != nvc_pkg::OP_NONE) && (hwdata[3:0] <= 4'h8);

   always_comb begin
      case (haddr[7:0])
         `NVC_OFF_CTRL: rd_mux = {28'h0000000, op_ff};
         `NVC_OFF_ADDR: rd_mux = {15'h0000, addr_ff};
         `NVC_OFF_DATA: rd_mux = {24'h000000, rdata_ff};
         `NVC_OFF_STAT: rd_mux = {29'h00000000, done_ff, refused_ff,
                                  state_ff != nvc_pkg::ST_IDLE};
         `NVC_OFF_TSET_LO: rd_mux = tset_ff[31:0];
         `NVC_OFF_TSET_HI: rd_mux = tset_ff[63:32];
         `NVC_OFF_TSNP_LO: rd_mux = tsnap_ff[31:0];
         `NVC_OFF_TSNP_HI: rd_mux = tsnap_ff[63:32];
         default: rd_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         a_act_ff <= 1'b0;
         a_wr_ff <= 1'b0;
         a_off_ff <= 8'h00;
         hrdata_ff <= 32'h00000000;
         hreadyout_ff <= 1'b0;
      end else begin
         hreadyout_ff <= 1'b1;
         a_act_ff <= hready && hsel && htrans[1];
         a_wr_ff <= hwrite;
         a_off_ff <= haddr[7:0];
         if (hready && hsel && htrans[1] && !hwrite) begin
            hrdata_ff <= rd_mux;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         addr_ff <= 17'h00000;
         wdata_ff <= 8'h00;
         tset_ff <= 64'h0000000000000000;
      end else if (a_act_ff && a_wr_ff) begin
         case (a_off_ff)
            `NVC_OFF_ADDR: addr_ff <= hwdata[16:0];
            `NVC_OFF_DATA: wdata_ff <= hwdata[7:0];
            `NVC_OFF_TSET_LO: tset_ff[31:0] <= hwdata;
            `NVC_OFF_TSET_HI: tset_ff[63:32] <= hwdata;
            default: ;
         endcase
      end
   end

   // sticky status; hardware set wins over software clear
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         refused_ff <= 1'b0;
         done_ff <= 1'b0;
      end else begin
         if (refuse) begin
            refused_ff <= 1'b1;
         end else if (a_act_ff && a_wr_ff && (a_off_ff == `NVC_OFF_STAT) &&
                      hwdata[`NVC_ST_REFUSED]) begin
            refused_ff <= 1'b0;
         end
         if (((state_ff == nvc_pkg::ST_HOLD) && last_step && (op_ff != nvc_pkg::OP_SAVE) &&
              (op_ff != nvc_pkg::OP_RESTORE)) ||
             ((state_ff == nvc_pkg::ST_WAIT) && (cnt_ff == 12'h000))) begin
            done_ff <= 1'b1;
         end else if (a_act_ff && a_wr_ff && (a_off_ff == `NVC_OFF_STAT) &&
                      hwdata[`NVC_ST_DONE]) begin
            done_ff <= 1'b0;
         end
      end
   end

   // current step of the running operation
   assign bidx = 3'(idx_ff - 4'h1);
   assign last_step = (idx_ff == 4'(op_len(op_ff) - 4'h1));

   always_comb begin
      st_addr = addr_ff;
      st_wr = 1'b0;
      st_dat = wdata_ff;
      case (op_ff)
         nvc_pkg::OP_WRITE: st_wr = 1'b1;
         nvc_pkg::OP_SAVE, nvc_pkg::OP_RESTORE, nvc_pkg::OP_AS_DIS, nvc_pkg::OP_AS_EN: begin
            st_addr = {1'b0, seq_addr(op_ff, idx_ff)};
         end
         nvc_pkg::OP_TRD, nvc_pkg::OP_TWR: begin
            if (idx_ff == 4'd0) begin
               st_addr = `NVC_DEV_FLAGS;
               st_wr = 1'b1;
               st_dat = (op_ff == nvc_pkg::OP_TRD) ? `NVC_FLAG_RHOLD : `NVC_FLAG_WHOLD;
            end else if (idx_ff == 4'd9) begin
               st_addr = `NVC_DEV_FLAGS;
               st_wr = 1'b1;
               st_dat = `NVC_FLAG_NONE;
            end else begin
               st_addr = 17'(`NVC_DEV_CLK_BASE + {14'h0000, bidx});
               st_wr = (op_ff == nvc_pkg::OP_TWR);
               st_dat = tset_ff[8 * bidx +: 8];
            end
         end
         default: ;
      endcase
   end

   // pin cycle sequencer
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         state_ff <= nvc_pkg::ST_IDLE;
         op_ff <= nvc_pkg::OP_NONE;
         idx_ff <= 4'h0;
         cnt_ff <= 12'h000;
         pins_ff <= '{addr: 17'h00000, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
                      dq_out: 8'h00, dq_oe: 1'b0};
      end else begin
         case (state_ff)
            nvc_pkg::ST_IDLE: begin
               if (start) begin
                  op_ff <= req_op;
                  idx_ff <= 4'h0;
                  state_ff <= nvc_pkg::ST_SETUP;
               end
            end
            nvc_pkg::ST_SETUP: begin
               pins_ff.addr <= st_addr;
               pins_ff.dq_out <= st_dat;
               pins_ff.dq_oe <= st_wr;
               state_ff <= nvc_pkg::ST_ACT;
            end
            nvc_pkg::ST_ACT: begin
               pins_ff.ce_n <= 1'b0;
               pins_ff.we_n <= !st_wr;
               pins_ff.oe_n <= st_wr;
               cnt_ff <= 12'(`NVC_ACC_CYC - 1);
               state_ff <= nvc_pkg::ST_STRB;
            end
            nvc_pkg::ST_STRB: begin
               if (cnt_ff == 12'h000) begin
                  pins_ff.ce_n <= 1'b1;
                  pins_ff.we_n <= 1'b1;
                  pins_ff.oe_n <= 1'b1;
                  state_ff <= nvc_pkg::ST_HOLD;
               end else begin
                  cnt_ff <= cnt_ff - 12'h001;
               end
            end
            nvc_pkg::ST_HOLD: begin
               pins_ff.dq_oe <= 1'b0;
               if (!last_step) begin
                  idx_ff <= idx_ff + 4'h1;
                  state_ff <= nvc_pkg::ST_SETUP;
               end else if (op_ff == nvc_pkg::OP_SAVE) begin
                  cnt_ff <= 12'(`NVC_SAVE_CYC - 1);
                  state_ff <= nvc_pkg::ST_WAIT;
               end else if (op_ff == nvc_pkg::OP_RESTORE) begin
                  cnt_ff <= 12'(`NVC_RESTORE_CYC - 1);
                  state_ff <= nvc_pkg::ST_WAIT;
               end else begin
                  state_ff <= nvc_pkg::ST_IDLE;
               end
            end
            nvc_pkg::ST_WAIT: begin
               if (cnt_ff == 12'h000) begin
                  state_ff <= nvc_pkg::ST_IDLE;
               end else begin
                  cnt_ff <= cnt_ff - 12'h001;
               end
            end
            default: state_ff <= nvc_pkg::ST_IDLE;
         endcase
      end
   end

   // read capture while strobes are still low
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         rdata_ff <= 8'h00;
         tsnap_ff <= 64'h0000000000000000;
      end else if ((state_ff == nvc_pkg::ST_STRB) && (cnt_ff == 12'h000) && !st_wr) begin
         if (op_ff == nvc_pkg::OP_TRD) begin
            tsnap_ff[8 * bidx +: 8] <= mem_dq_in;
         end else begin
            rdata_ff <= mem_dq_in;
         end
      end
   end

   // hold bit written in this clock operation
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         hold_set_ff <= 1'b0;
      end else if (state_ff == nvc_pkg::ST_IDLE) begin
         hold_set_ff <= 1'b0;
      end else if ((state_ff == nvc_pkg::ST_HOLD) && is_clk(op_ff) && (idx_ff == 4'd0)) begin
         hold_set_ff <= 1'b1;
      end
   end

   assign hrdata = hrdata_ff;
   assign hreadyout = hreadyout_ff;
   assign hresp = 1'b0;
   assign mem_pins = pins_ff;

   seq_we_high_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (is_seq(op_ff) && !pins_ff.ce_n) |-> pins_ff.we_n && !pins_ff.dq_oe)
      else $error("write strobe low during special sequence");
   seq_prefix_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      ($fell(pins_ff.ce_n) && is_seq(op_ff) && (idx_ff == 4'd0)) |->
         (pins_ff.addr[15:0] == `NVC_SEQ_0) ##1 !pins_ff.ce_n[*4])
      else $error("sequence does not open with prefix address");
   seq_top_bit_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      ($fell(pins_ff.ce_n) && (op_ff == nvc_pkg::OP_SAVE) && (idx_ff == 4'd5)) |->
         (pins_ff.addr == {1'b0, `NVC_SEQ_SAVE}))
      else $error("save address wrong");
   read_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      ($fell(pins_ff.ce_n) && (op_ff == nvc_pkg::OP_TRD) && (idx_ff != 4'd0) &&
       (idx_ff != 4'd9)) |-> hold_set_ff && pins_ff.we_n)
      else $error("clock read without read hold");
   write_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      ($fell(pins_ff.ce_n) && (op_ff == nvc_pkg::OP_TWR) && (idx_ff != 4'd0)) |->
         hold_set_ff && !pins_ff.we_n)
      else $error("clock write without write hold");
   low_supply_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      refuse |=> (state_ff == nvc_pkg::ST_IDLE) && refused_ff)
      else $error("write or save started under low supply");
   strobe_fall_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      $fell(pins_ff.we_n) |-> $past(pins_ff.ce_n) && $past(pins_ff.dq_oe))
      else $error("write strobe fell without idle lead-in");
   save_wait_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      ($rose(pins_ff.ce_n) && (op_ff == nvc_pkg::OP_SAVE) && last_step) |->
         ##2 (state_ff == nvc_pkg::ST_WAIT) && pins_ff.ce_n)
      else $error("save wait not entered");

endmodule

// file: tb/nvc_dev_model.sv
// Purpose: behavioural model of the byte-wide nv memory with calendar clock
// Assumes: pins change only after clk_sys edges, accesses end when chip-select rises
// Notes: time counters stand still; undriven data toggles every cycle
`timescale 1ns/1ns
module nvc_dev_model #(
   parameter int T_NV = 1000 // cycles the port stays disabled after save or restore
) (
   input wire logic clk_sys, // system clock
   input wire nvc_pkg::nvc_pins_t pins, // controller pins
   input wire logic pwr_low, // supply below switch threshold
   output logic [7:0] dq = 8'h00 // data to controller
);
   logic [7:0] mem_ff [int];
   logic [7:0] nv_ff [int];
   logic [7:0] vis_ff [8];
   logic [7:0] live_ff [8];
   logic [7:0] flags_ff = 8'h00;
   logic [15:0] seq_c [5] = '{16'h4e38, 16'hb1c7, 16'h83e0, 16'h7c1f, 16'h703f};
   int step_ff = 0, busy_ff = 0, saves_ff = 0, restores_ff = 0;
   logic autosave_ff = 1'b1, wr_ok_ff = 1'b0, ce_ff = 1'b1, we_ff = 1'b1;
   wire logic [16:0] a = pins.addr;
   wire logic rd = !pins.ce_n && pins.we_n && !pins.oe_n && busy_ff == 0;

   function automatic logic [7:0] rdv(input logic [16:0] x);
      if (x == 17'h1fff0) return flags_ff & 8'h03;
      if (x >= 17'h1fff8) return vis_ff[x[2:0]];
      return mem_ff.exists(x) ? mem_ff[x] : 8'h00;
   endfunction

   task automatic wr_byte(input logic [16:0] x, input logic [7:0] d);
      if (x == 17'h1fff0) begin
         if (flags_ff[1] && !d[1]) live_ff <= vis_ff;
         flags_ff <= d & 8'h03;
      end else if (x >= 17'h1fff8) begin
         if (flags_ff[1]) vis_ff[x[2:0]] <= d;
      end else mem_ff[x] = d;
   endtask

   always @(posedge clk_sys) begin
      dq <= rd ? rdv(a) : ~dq;
      ce_ff <= pins.ce_n;
      we_ff <= pins.we_n;
      if (busy_ff > 0) busy_ff <= busy_ff - 1;
      if ((!pins.ce_n && ce_ff) || (!pins.we_n && we_ff)) wr_ok_ff <= 1'b1;
      if (!flags_ff[0] && !flags_ff[1]) vis_ff <= live_ff;
      if (pins.ce_n && !ce_ff && busy_ff == 0) begin
         if (!we_ff) begin
            step_ff <= 0;
            if (wr_ok_ff && !pwr_low) wr_byte(a, pins.dq_out);
         end else if (step_ff == 5) begin
            step_ff <= 0;
            case (a[15:0])
               16'h8fc0: if (!pwr_low) begin
                  nv_ff = mem_ff;
                  saves_ff <= saves_ff + 1;
                  busy_ff <= T_NV;
                  wr_ok_ff <= 1'b0;
               end
               16'h4c63: begin
                  mem_ff = nv_ff;
                  restores_ff <= restores_ff + 1;
                  busy_ff <= T_NV;
                  wr_ok_ff <= 1'b0;
               end
               16'h8b45: autosave_ff <= 1'b0;
               16'h4b46: autosave_ff <= 1'b1;
               default: ;
            endcase
         end else begin
            step_ff <= (a[15:0] == seq_c[step_ff]) ? step_ff + 1
                       : int'(a[15:0] == seq_c[0]);
         end
      end
   end
endmodule

// file: tb/tb.sv
// Purpose: self-checking bench for the nv memory controller
// Assumes: one AHB-Lite slave, zero wait states allowed but not relied on
// Notes: reads queue their expectation; a watcher compares at data-phase end
`timescale 1ns/1ns
`include "nvc_map.svh"
module tb;
   logic clk_sys = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic pwr_low = 1'b0, rd_ph = 1'b0, hreadyout, hresp;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdat;
   logic [1:0] htrans = 2'b00;
   logic [2:0] hsize = 3'h2;
   logic [7:0] dq;
   logic [31:0] exp_q [$];
   logic [7:0] d8 [4];
   logic [16:0] a17 [4];
   logic [31:0] tl = 32'h0831_2459, th = 32'h2026_1103;
   nvc_pkg::nvc_pins_t pins;
   int mismatches = 0, check_count = 0;

   always #5 clk_sys = ~clk_sys;

   nvc_ctrl i_nvc_ctrl(.clk_sys(clk_sys), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mem_pins(pins),
      .mem_dq_in(dq), .pwr_low(pwr_low));
   nvc_dev_model dev(.clk_sys(clk_sys), .pins(pins), .pwr_low(pwr_low), .dq(dq));

   task finish_test;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task check(input logic [31:0] got, input logic [31:0] e, input string m);
      check_count++;
      if (got !== e) begin
         mismatches++;
         $display("mismatch at %0t: %s got %h expected %h", $time, m, got, e);
      end
   endtask

   always @(posedge clk_sys) if (rd_ph && hreadyout === 1'b1) check(hrdata, exp_q.pop_front(), "read");

   task wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (hreadyout !== 1'b1 && n < 64);
      if (n >= 64) begin
         mismatches++;
         $display("mismatch at %0t: bus never ready", $time);
         finish_test;
      end
   endtask

   task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c,
            input logic [31:0] e);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'b10;
      wait_rdy;
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= d;
      rd_ph <= c && !w;
      if (c && !w) exp_q.push_back(e);
      wait_rdy;
      rdat = hrdata;
      rd_ph <= 1'b0;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 1'b0, 32'h0);
   endtask

   task rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, 1'b1, e);
   endtask

   task op(input logic [3:0] c);
      int n;
      wr(`NVC_OFF_STAT, 32'h6);
      wr(`NVC_OFF_CTRL, {28'h0, c});
      n = 0;
      do begin
         bus(1'b0, `NVC_OFF_STAT, 32'h0, 1'b0, 32'h0);
         n++;
      end while ((rdat[`NVC_ST_DONE] | rdat[`NVC_ST_REFUSED]) !== 1'b1 && n < 3000);
      if (n >= 3000) begin
         mismatches++;
         $display("mismatch at %0t: operation never ended", $time);
         finish_test;
      end
   endtask

   task mwr(input logic [16:0] a, input logic [7:0] d);
      wr(`NVC_OFF_ADDR, {15'h0, a});
      wr(`NVC_OFF_DATA, {24'h0, d});
      op(4'h2);
   endtask

   task mrd(input logic [16:0] a, input logic [7:0] e);
      wr(`NVC_OFF_ADDR, {15'h0, a});
      op(4'h1);
      rd(`NVC_OFF_DATA, {24'h0, e});
   endtask

   initial begin
      #900000;
      mismatches++;
      $display("mismatch at %0t: run too long", $time);
      finish_test;
   end

   initial begin
      check_count = $urandom(32'h8402);
      check_count = 0;
      repeat (6) @(posedge clk_sys);
      reset_n <= 1'b1;
      @(posedge clk_sys);
      check({pins.ce_n, pins.we_n, pins.oe_n, pins.dq_oe}, 4'b1110, "idle pins");
      check({31'h0, hresp}, 32'h0, "okay response");
      rd(`NVC_OFF_STAT, 32'h0);
      rd(8'h40, 32'h0);
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         a17[i] = (17'($urandom) & 17'h1f7fc) | 17'(i);
         d8[i] = 8'($urandom);
         mwr(a17[i], d8[i]);
         rd(`NVC_OFF_STAT, 32'h4);
      end
      for (int i = 0; i < 4; i++) begin
         check(dev.mem_ff[a17[i]], d8[i], "array write");
         mrd(a17[i], d8[i]);
      end
      $display("test array done");
      pwr_low <= 1'b1;
      mwr(a17[0], ~d8[0]);
      rd(`NVC_OFF_STAT, 32'h2);
      op(4'h3);
      rd(`NVC_OFF_STAT, 32'h2);
      check(dev.saves_ff, 0, "save under low supply");
      pwr_low <= 1'b0;
      mrd(a17[0], d8[0]);
      $display("test low supply done");
      mrd(17'h04e38, 8'h00);
      op(4'h3);
      check(dev.saves_ff, 1, "save count");
      mwr(a17[1], ~d8[1]);
      op(4'h4);
      check(dev.restores_ff, 1, "restore count");
      mrd(a17[1], d8[1]);
      op(4'h5);
      check(dev.autosave_ff, 0, "autosave off");
      op(4'h6);
      check(dev.autosave_ff, 1, "autosave on");
      $display("test nv done");
      wr(`NVC_OFF_TSET_LO, tl);
      wr(`NVC_OFF_TSET_HI, th);
      op(4'h8);
      for (int i = 0; i < 4; i++) begin
         check(dev.live_ff[i], tl[8*i+:8], "live time");
         check(dev.live_ff[i+4], th[8*i+:8], "live time");
      end
      op(4'h7);
      rd(`NVC_OFF_TSNP_LO, tl);
      rd(`NVC_OFF_TSNP_HI, th);
      check(dev.flags_ff, 0, "flags released");
      $display("test clock done");
      repeat (2) @(posedge clk_sys);
      finish_test;
   end
endmodule
